// ### frio_pkg.sv
// Package with constants and types for the fieldbus remote I/O handshake block.
`default_nettype none
package frio_pkg;
  localparam int FRIO_STATION_W = 6;
  localparam int FRIO_BANK_W = 16;
  localparam int FRIO_WORD_W = 16;
  localparam int FRIO_CODE_W = 16;
  // Bit and word blocks per station.
  localparam int FRIO_BITS_PER_STATION = 32;
  localparam int FRIO_WORDS_PER_STATION = 4;
  // Status bit positions in the first and second remote-input words.
  localparam int FRIO_POS_FWD = 0;
  localparam int FRIO_POS_REV = 1;
  localparam int FRIO_POS_GEN0 = 2;
  localparam int FRIO_POS_TRIP = 7;
  localparam int FRIO_POS_TERM0 = 8;
  localparam int FRIO_POS_MON = 12;
  localparam int FRIO_POS_SPD = 13;
  localparam int FRIO_POS_CMD = 15;
  localparam int FRIO_POS_ALARM = 10;
  localparam int FRIO_POS_READY = 11;
  localparam logic [FRIO_BANK_W-1:0] FRIO_RST_BANK = 16'h0000;
  localparam logic [FRIO_WORD_W-1:0] FRIO_RST_WORD = 16'h0000;
  localparam logic [1:0] FRIO_LINK_CMD_ON = 2'h2;
  typedef enum logic [1:0] {FRIO_CMD_IDLE, FRIO_CMD_BUSY, FRIO_CMD_DONE} frio_cmd_state_t;
endpackage : frio_pkg
`default_nettype wire

// ### frio_edge.sv
// Rising-edge detector, used for the command execution request handshake.
`default_nettype none
module frio_edge
  import frio_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Level in, pulse out
  input wire logic level,
  output logic rise
);
  logic prev;

  assign rise = level & ~prev;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prev <= 1'b0;
    end else begin
      prev <= level;
    end
  end
endmodule : frio_edge
`default_nettype wire

// ### frio_handshake.sv
// Remote-input status bits and request/acknowledge handshakes of the fieldbus option.
//
// Contract
// - Bit and word blocks sit at a base index derived from station address.
// - While monitor request holds, monitored values refresh every cycle.
// - Monitoring-active flag clears whenever monitor request is deasserted.
// - Speed-write-done sets after reference stored; clears when request withdrawn.
// - Command code executes once per rising edge of execution request.
// - Command-done asserts after processing; clears when request removed.
// - Alarm reset is applied continuously while alarm clear request holds.
// - Alarm reset works regardless of operation mode.
// - Forward-running bit is set only while rotating forward.
// - Reverse-running bit is set only while rotating in reverse.
// - Trip bit is set when protection operated and output shut off.
// - Alarm flag follows drive alarm, except the one excluded alarm type.
// - Station-ready sets after initial setup following power-on or reset.
// - Station-ready drops in the same update the alarm flag rises.
// - General status bits report speed and ready conditions; others are terminals.
// - With link commands disabled, run is ignored but done flags still assert.
`default_nettype none
module frio_handshake
  import frio_pkg::*;
#(
  parameter int STATION_W = FRIO_STATION_W,
  parameter int WORD_W = FRIO_WORD_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Configuration
  input wire logic [STATION_W-1:0] station_address,
  input wire logic [1:0] link_command_select,
  input wire logic link_enable_input,
  output logic [STATION_W+4:0] bit_base_index,
  output logic [STATION_W+1:0] word_base_index,
  // Requests from the master
  input wire logic monitor_request,
  input wire logic speed_write_request,
  input wire logic cmd_exec_request,
  input wire logic alarm_clear_request,
  input wire logic run_fwd_request,
  input wire logic run_rev_request,
  input wire logic [WORD_W-1:0] speed_reference_word,
  input wire logic [FRIO_CODE_W-1:0] cmd_code_word,
  // Drive core status
  input wire logic setup_complete,
  input wire logic motor_fwd,
  input wire logic motor_rev,
  input wire logic trip_active,
  input wire logic alarm_raised,
  input wire logic alarm_excluded,
  input wire logic [4:0] general_status,
  input wire logic [3:0] terminal_status,
  input wire logic [WORD_W-1:0] monitor_value_one,
  input wire logic [WORD_W-1:0] monitor_value_two,
  input wire logic speed_stored,
  input wire logic cmd_finished,
  // Drive core commands
  output logic alarm_reset,
  output logic run_fwd_cmd,
  output logic run_rev_cmd,
  output logic cmd_start,
  output logic [FRIO_CODE_W-1:0] cmd_code,
  output logic speed_write_strobe,
  output logic [WORD_W-1:0] speed_reference,
  // Remote input to the master
  output logic [FRIO_BANK_W-1:0] status_word_lo,
  output logic [FRIO_BANK_W-1:0] status_word_hi,
  output logic [WORD_W-1:0] monitored_one,
  output logic [WORD_W-1:0] monitored_two
);
  logic monitor_active_flag;
  logic speed_write_done;
  logic cmd_exec_done;
  logic alarm_flag;
  logic station_ready;
  logic cmd_rise;
  logic link_cmd_ok;
  logic alarm_event;
  frio_cmd_state_t cmd_state;
  frio_cmd_state_t next_cmd_state;
  logic [FRIO_BANK_W-1:0] next_lo;
  logic [FRIO_BANK_W-1:0] next_hi;

  frio_edge u_cmd_edge (
    .clk(clk),
    .sys_rst(sys_rst),
    .level(cmd_exec_request),
    .rise(cmd_rise)
  );

  assign bit_base_index = {station_address, 5'h00};
  assign word_base_index = {station_address, 2'h0};
  // Run commands from the link need both the selector and the enable input.
  assign link_cmd_ok = (link_command_select == FRIO_LINK_CMD_ON) & link_enable_input;
  assign run_fwd_cmd = link_cmd_ok & run_fwd_request & ~run_rev_request;
  assign run_rev_cmd = link_cmd_ok & run_rev_request & ~run_fwd_request;
  assign alarm_reset = alarm_clear_request;
  assign cmd_start = cmd_rise & (cmd_state == FRIO_CMD_IDLE);
  assign speed_write_strobe = speed_write_request;
  assign alarm_event = alarm_raised & ~alarm_excluded;

  always_comb begin
    next_cmd_state = cmd_state;
    case (cmd_state)
      FRIO_CMD_IDLE: begin
        if (cmd_rise) begin
          next_cmd_state = FRIO_CMD_BUSY;
        end
      end
      FRIO_CMD_BUSY: begin
        if (!cmd_exec_request) begin
          next_cmd_state = FRIO_CMD_IDLE;
        end else if (cmd_finished) begin
          next_cmd_state = FRIO_CMD_DONE;
        end
      end
      FRIO_CMD_DONE: begin
        if (!cmd_exec_request) begin
          next_cmd_state = FRIO_CMD_IDLE;
        end
      end
      default: begin
        next_cmd_state = FRIO_CMD_IDLE;
      end
    endcase
  end

  always_comb begin
    next_lo = FRIO_RST_BANK;
    next_lo[FRIO_POS_FWD] = motor_fwd & ~motor_rev;
    next_lo[FRIO_POS_REV] = motor_rev & ~motor_fwd;
    next_lo[FRIO_POS_GEN0 +: 5] = general_status;
    next_lo[FRIO_POS_TRIP] = trip_active;
    next_lo[FRIO_POS_TERM0 +: 4] = terminal_status;
    next_lo[FRIO_POS_MON] = monitor_active_flag;
    next_lo[FRIO_POS_SPD] = speed_write_done;
    next_lo[FRIO_POS_CMD] = cmd_exec_done;
    next_hi = FRIO_RST_BANK;
    next_hi[FRIO_POS_ALARM] = alarm_flag;
    next_hi[FRIO_POS_READY] = station_ready;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmd_state <= FRIO_CMD_IDLE;
      monitor_active_flag <= 1'b0;
      speed_write_done <= 1'b0;
      cmd_exec_done <= 1'b0;
      alarm_flag <= 1'b0;
      station_ready <= 1'b0;
    end else begin
      cmd_state <= next_cmd_state;
      monitor_active_flag <= monitor_request;
      speed_write_done <= speed_write_request & (speed_write_done | speed_stored);
      cmd_exec_done <= cmd_exec_request & (next_cmd_state == FRIO_CMD_DONE);
      alarm_flag <= alarm_event;
      // A new alarm drops ready in the same cycle the alarm flag rises.
      station_ready <= setup_complete & ~alarm_event;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      monitored_one <= FRIO_RST_WORD;
      monitored_two <= FRIO_RST_WORD;
      speed_reference <= FRIO_RST_WORD;
      cmd_code <= FRIO_RST_WORD;
      status_word_lo <= FRIO_RST_BANK;
      status_word_hi <= FRIO_RST_BANK;
    end else begin
      if (monitor_request) begin
        monitored_one <= monitor_value_one;
        monitored_two <= monitor_value_two;
      end
      if (speed_write_request) begin
        speed_reference <= speed_reference_word;
      end
      if (cmd_rise) begin
        cmd_code <= cmd_code_word;
      end
      status_word_lo <= next_lo;
      status_word_hi <= next_hi;
    end
  end

  monitor_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    !monitor_request |=> !monitor_active_flag) else $error("monitor flag stayed set");
  monitor_refresh_a: assert property (@(posedge clk) disable iff (sys_rst)
    monitor_request |=> monitored_one == $past(monitor_value_one)) else $error("monitor not refreshed");
  speed_done_a: assert property (@(posedge clk) disable iff (sys_rst)
    speed_write_request && speed_stored |=> speed_write_done) else $error("speed done missing");
  speed_drop_a: assert property (@(posedge clk) disable iff (sys_rst)
    !speed_write_request |=> !speed_write_done) else $error("speed done stuck");
  cmd_once_a: assert property (@(posedge clk) disable iff (sys_rst)
    cmd_start |=> !cmd_start [*3]) else $error("command started twice");
  cmd_drop_a: assert property (@(posedge clk) disable iff (sys_rst)
    !cmd_exec_request |=> !cmd_exec_done) else $error("command done stuck");
  alarm_reset_a: assert property (@(posedge clk) disable iff (sys_rst)
    alarm_clear_request |-> alarm_reset) else $error("alarm reset missing");
  dir_excl_a: assert property (@(posedge clk) disable iff (sys_rst)
    !(status_word_lo[FRIO_POS_FWD] && status_word_lo[FRIO_POS_REV])) else $error("both directions");
  ready_drop_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(alarm_flag) |-> !station_ready) else $error("ready held on alarm");
  unused_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
    status_word_hi[9:0] == 10'h000 && status_word_hi[15:12] == 4'h0) else $error("unused bit set");
  unused_lo_a: assert property (@(posedge clk) disable iff (sys_rst)
    !status_word_lo[FRIO_POS_SPD+1]) else $error("unused low bit set");
  run_block_a: assert property (@(posedge clk) disable iff (sys_rst)
    !link_enable_input |-> !run_fwd_cmd && !run_rev_cmd) else $error("run while disabled");

  cmd_flow_c: cover property (@(posedge clk) disable iff (sys_rst) cmd_start ##[1:20] cmd_exec_done);
  speed_flow_c: cover property (@(posedge clk) disable iff (sys_rst) $rose(speed_write_done));
  alarm_flow_c: cover property (@(posedge clk) disable iff (sys_rst) $rose(alarm_flag) ##[1:20] alarm_reset);
  ready_flow_c: cover property (@(posedge clk) disable iff (sys_rst) $rose(station_ready));
endmodule : frio_handshake
`default_nettype wire

// ### frio_core_model.sv
// Behavioural drive core that acknowledges speed writes and command starts.
`default_nettype none
module frio_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // From the block
  input wire logic cmd_start,
  input wire logic speed_write_strobe,
  input wire logic slow,
  // Answers
  output logic cmd_finished,
  output logic speed_stored
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] count;
  // Slow mode keeps a command busy for several cycles, so a held request is seen not to start it again.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count <= 4'h0;
    end else if (cmd_start) begin
      count <= slow ? 4'h6 : 4'h1;
    end else if (count != 4'h0) begin
      count <= count - 4'h1;
    end
  end
  always_ff @(posedge clk) begin
    speed_stored <= speed_write_strobe & ~sys_rst;
  end
  assign cmd_finished = (count == 4'h1);
endmodule : frio_core_model
`default_nettype wire

// ### frio_handshake_tb_top.sv
// Self-checking testbench for the fieldbus remote I/O handshake block.
`default_nettype none
module frio_handshake_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import frio_pkg::*;
  logic clk, sys_rst, link_enable_input, monitor_request, speed_write_request, cmd_exec_request, slow;
  logic alarm_clear_request, run_fwd_request, run_rev_request, setup_complete, motor_fwd, motor_rev;
  logic trip_active, alarm_raised, alarm_excluded, speed_stored, cmd_finished, alarm_reset, run_fwd_cmd;
  logic run_rev_cmd, cmd_start, speed_write_strobe;
  logic [5:0] station_address;
  logic [1:0] link_command_select;
  logic [10:0] bit_base_index;
  logic [7:0] word_base_index;
  logic [4:0] general_status;
  logic [3:0] terminal_status;
  logic [15:0] speed_reference_word, cmd_code_word, monitor_value_one, monitor_value_two, cmd_code;
  logic [15:0] speed_reference, status_word_lo, status_word_hi, monitored_one, monitored_two;
  int mismatches = 0;
  int n_checks = 0;
  int n_start = 0;
  logic link_error;
  logic [15:0] held_status_hi;
  frio_handshake u_frio_handshake (.clk, .sys_rst, .station_address, .link_command_select, .link_enable_input,
    .bit_base_index, .word_base_index, .monitor_request, .speed_write_request, .cmd_exec_request,
    .alarm_clear_request, .run_fwd_request, .run_rev_request, .speed_reference_word, .cmd_code_word,
    .setup_complete, .motor_fwd, .motor_rev, .trip_active, .alarm_raised, .alarm_excluded, .general_status,
    .terminal_status, .monitor_value_one, .monitor_value_two, .speed_stored, .cmd_finished, .alarm_reset,
    .run_fwd_cmd, .run_rev_cmd, .cmd_start, .cmd_code, .speed_write_strobe, .speed_reference,
    .status_word_lo, .status_word_hi, .monitored_one, .monitored_two);
  frio_core_model u_frio_core_model (.clk, .sys_rst, .cmd_start, .speed_write_strobe, .slow, .cmd_finished,
    .speed_stored);
  task automatic tally_and_finish();
    if (mismatches == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic wait_lo(input int pos, input logic v);
    @(negedge clk);
    for (int i = 0; i < 30 && status_word_lo[pos] !== v; i++) @(negedge clk);
    check("status flag", 16'(status_word_lo[pos]), 16'(v));
    tick(1);
  endtask : wait_lo
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (cmd_start === 1'b1) n_start++;
  end
  // A master set to keep input data on a link error freezes its copy of the station's flags.
  always @(posedge clk) begin
    if (link_error === 1'b0) held_status_hi <= status_word_hi;
  end
  initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end
  initial begin
    {link_enable_input, monitor_request, speed_write_request, cmd_exec_request, alarm_clear_request, link_error} = '0;
    {run_fwd_request, run_rev_request, setup_complete, motor_fwd, motor_rev, trip_active} = '0;
    {alarm_raised, alarm_excluded, slow, link_command_select, general_status, terminal_status} = '0;
    {station_address, speed_reference_word, cmd_code_word} = {6'h05, 16'h1388, 16'h0000};
    {monitor_value_one, monitor_value_two, sys_rst} = {16'h1234, 16'hbeef, 1'b1};
    tick(4);
    sys_rst <= 1'b0;
    tick(1);
    #1 check("low status", status_word_lo, 16'h0000);
    check("high status", status_word_hi, 16'h0000);
    check("bit base", 16'(bit_base_index), 16'h00a0);
    check("word base", 16'(word_base_index), 16'h0014);
    tick(1);
    {motor_fwd, trip_active, general_status, terminal_status, setup_complete} <= {2'b11, 5'h15, 4'ha, 1'b1};
    tick(3);
    #1 check("run flags", status_word_lo, {4'h0, 4'ha, 1'b1, 5'h15, 2'b01});
    check("ready", status_word_hi, 16'h0800);
    tick(1);
    {motor_fwd, motor_rev, alarm_raised} <= 3'b011;
    tick(3);
    #1 check("reverse", 16'(status_word_lo[1:0]), 16'h0002);
    check("alarm", status_word_hi, 16'h0400);
    tick(1);
    alarm_clear_request <= 1'b1;
    alarm_excluded <= 1'b1;
    tick(3);
    #1 check("alarm reset", 16'(alarm_reset), 16'h0001);
    check("excluded", status_word_hi, 16'h0800);
    tick(1);
    {alarm_raised, alarm_excluded} <= 2'b00;
    tick(1);
    alarm_clear_request <= 1'b0;
    monitor_request <= 1'b1;
    tick(3);
    #1 check("monitor one", monitored_one, 16'h1234);
    tick(1);
    monitor_value_one <= 16'h5678;
    tick(2);
    #1 check("refresh", monitored_one, 16'h5678);
    check("monitor two", monitored_two, 16'hbeef);
    wait_lo(FRIO_POS_MON, 1'b1);
    monitor_request <= 1'b0;
    wait_lo(FRIO_POS_MON, 1'b0);
    run_fwd_request <= 1'b1;
    speed_write_request <= 1'b1;
    tick(2);
    #1 check("run blocked", 16'(run_fwd_cmd), 16'h0000);
    check("speed copy", speed_reference, 16'h1388);
    wait_lo(FRIO_POS_SPD, 1'b1);
    speed_write_request <= 1'b0;
    wait_lo(FRIO_POS_SPD, 1'b0);
    for (int k = 0; k < 2; k++) begin
      slow <= k[0];
      cmd_code_word <= 16'h00a5 + 16'(k);
      tick(1);
      cmd_exec_request <= 1'b1;
      tick(12);
      #1 check("starts", 16'(n_start), 16'(k + 1));
      check("code", cmd_code, 16'h00a5 + 16'(k));
      wait_lo(FRIO_POS_CMD, 1'b1);
      cmd_exec_request <= 1'b0;
      wait_lo(FRIO_POS_CMD, 1'b0);
    end
    {link_command_select, link_enable_input} <= {FRIO_LINK_CMD_ON, 1'b1};
    tick(2);
    #1 check("run enabled", 16'(run_fwd_cmd), 16'h0001);
    tick(1);
    run_fwd_request <= 1'b0;
    tick(2);
    #1 check("run released", 16'(run_fwd_cmd), 16'h0000);
    tick(1);
    run_rev_request <= 1'b1;
    tick(1);
    #1 check("reverse run", 16'(run_rev_cmd), 16'h0001);
    tick(1);
    run_fwd_request <= 1'b1;
    tick(1);
    #1 check("run conflict", 16'({run_fwd_cmd, run_rev_cmd}), 16'h0000);
    tick(1);
    {run_fwd_request, link_enable_input, alarm_clear_request} <= 3'b001;
    tick(1);
    #1 check("enable off", 16'(run_rev_cmd), 16'h0000);
    check("reset in link mode", 16'(alarm_reset), 16'h0001);
    tick(1);
    {alarm_clear_request, run_rev_request, link_error, alarm_raised} <= 4'b0011;
    tick(3);
    #1 check("alarm drops ready", status_word_hi, 16'h0400);
    check("held on link error", held_status_hi, 16'h0800);
    tick(1);
    {alarm_raised, link_error, sys_rst} <= 3'b001;
    tick(2);
    sys_rst <= 1'b0;
    #1 check("status in reset", status_word_hi, 16'h0000);
    tick(2);
    #1 check("ready after reset", status_word_hi, 16'h0800);
    tally_and_finish();
  end
endmodule : frio_handshake_tb_top
`default_nettype wire
